// File: src/mos_top.sv
// holds the status output select, speed limits, trip reset and display logic
// assumes all inputs are synchronous to core_clk and the register port
// never issues read and write strobes in the same cycle
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "mos_params.svh"
module mos_top #(
    parameter int TRIP_HOLD_CYC = `MOS_TRIP_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic trip_active,
    input wire logic trip_reset_req,
    input wire logic [9:0] analog_code,
    input wire logic [15:0] measured_speed,
    input wire logic motor_running,
    input wire logic motor_free_run,
    input wire logic motor_ccw,
    input wire logic motor_cw,
    input wire logic dir_changing,
    input wire logic [7:0] load_pct,
    input wire logic [7:0] torque_pct,
    input wire logic [7:0] avg_load_pct,
    input wire logic [15:0] dc_bus_volt,
    input wire logic rotor_edge,
    output logic general_status_output,
    output logic trip_reset_accept,
    output logic [15:0] speed_command,
    output logic [7:0] torque_limit_pct,
    output logic [16:0] display_value,
    output mos_pkg::mos_mon_type display_item
);
    import mos_pkg::*;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    logic [15:0] ctrl_r; // source, polarity, pulse count, monitor
    logic [15:0] low_lim_r; // speed at zero volts
    logic [15:0] up_lim_r; // speed at five volts, clamp
    logic [7:0] torq_r; // torque limit percent
    logic [15:0] match_r; // arrival window
    logic [15:0] int_spd_r; // stored internal speed, unclamped
    logic [15:0] disp_num_r; // display numerator
    logic [15:0] disp_den_r; // display denominator
    logic [15:0] rdata_r; // read data, one cycle after strobe
    logic [15:0] rd_mux_w;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    wire wr_ctrl_w = reg_wr && (reg_addr == `MOS_A_CTRL);
    wire wr_low_w = reg_wr && (reg_addr == `MOS_A_LOW_LIM);
    wire wr_up_w = reg_wr && (reg_addr == `MOS_A_UP_LIM);
    wire wr_torq_w = reg_wr && (reg_addr == `MOS_A_TORQ);
    wire wr_match_w = reg_wr && (reg_addr == `MOS_A_MATCH);
    wire wr_int_w = reg_wr && (reg_addr == `MOS_A_INT_SPD);
    wire wr_num_w = reg_wr && (reg_addr == `MOS_A_DISP_NUM);
    wire wr_den_w = reg_wr && (reg_addr == `MOS_A_DISP_DEN);

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    mos_src_type src_w; // selected status source
    mos_mon_type mon_w; // selected monitor item
    wire pol_w = ctrl_r[`MOS_F_POL]; // invert status output
    wire [2:0] pcnt_w = ctrl_r[`MOS_F_PCNT]; // pulses per rev code
    wire analog_sel_w = ctrl_r[`MOS_F_ANALOG]; // analogue_speed_source
    assign src_w = mos_src_type'(ctrl_r[`MOS_F_SRC]);

    // illegal monitor codes fall back to rotation speed
    always_comb begin
        unique case (ctrl_r[`MOS_F_MON])
            3'h1: mon_w = MOS_MON_TORQUE;
            3'h2: mon_w = MOS_MON_AVG_LOAD;
            3'h3: mon_w = MOS_MON_SPD_CMD;
            3'h4: mon_w = MOS_MON_DC_VOLT;
            default: mon_w = MOS_MON_SPEED;
        endcase
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `MOS_RST_CTRL;
            low_lim_r <= `MOS_RST_LOW;
            up_lim_r <= `MOS_RST_UP;
            torq_r <= `MOS_RST_TORQ;
            match_r <= `MOS_RST_MATCH;
            int_spd_r <= `MOS_RST_LOW;
            disp_num_r <= `MOS_RST_ONE;
            disp_den_r <= `MOS_RST_ONE;
        end else begin
            if (wr_ctrl_w) ctrl_r <= reg_wdata;
            if (wr_low_w) low_lim_r <= reg_wdata;
            if (wr_up_w) up_lim_r <= reg_wdata;
            if (wr_torq_w) torq_r <= reg_wdata[7:0];
            if (wr_match_w) match_r <= reg_wdata;
            if (wr_int_w) int_spd_r <= reg_wdata;
            if (wr_num_w) disp_num_r <= reg_wdata;
            if (wr_den_w) disp_den_r <= reg_wdata;
        end
    end

    // percent passes straight on; the drive uses it only as a guide
    assign torque_limit_pct = torq_r;

    // ----------------------------------------
    // speed command
    // ----------------------------------------
    // clamp against up_lim_r applied on read so a later lowered upper limit still binds
    wire [15:0] int_clamp_w = (int_spd_r > up_lim_r) ? up_lim_r : int_spd_r;
    // span is zero when limits are crossed, then low limit wins
    wire [15:0] span_w = (up_lim_r > low_lim_r) ? up_lim_r - low_lim_r : 16'h0000;
    wire [25:0] prod_w = span_w * analog_code;
    wire [15:0] scaled_w = prod_w[25:`MOS_ADC_SHIFT];
    // full code hits the upper limit exactly, shift alone falls short
    wire [15:0] analog_spd_w = (analog_code == `MOS_ADC_FULL) ? low_lim_r + span_w
                               : low_lim_r + scaled_w;
    wire [15:0] cmd_nxt = analog_sel_w ? analog_spd_w : int_clamp_w;
    logic [15:0] cmd_r;

    // registered so arrival and display see a steady value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= `MOS_RST_LOW;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end
    assign speed_command = cmd_r;

    // ----------------------------------------
    // trip reset qualification
    // ----------------------------------------
    logic [23:0] hold_r; // cycles the reset request has been held
    logic done_r; // reset already issued for this press
    logic accept_r;
    wire hold_full_w = (hold_r >= 24'(TRIP_HOLD_CYC - 1));
    // request counts only while a trip stands
    wire qual_w = trip_reset_req && trip_active;

    // one pulse per press; a released request restarts the count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 24'h000000;
            done_r <= 1'b0;
            accept_r <= 1'b0;
        end else if (!qual_w) begin
            hold_r <= 24'h000000;
            done_r <= 1'b0;
            accept_r <= 1'b0;
        end else begin
            hold_r <= hold_full_w ? hold_r : hold_r + 24'h000001;
            accept_r <= hold_full_w && !done_r;
            done_r <= done_r || hold_full_w;
        end
    end
    assign trip_reset_accept = accept_r;

    // ----------------------------------------
    // arrival detection
    // ----------------------------------------
    wire [15:0] err_w = (measured_speed > cmd_r) ? measured_speed - cmd_r
                        : cmd_r - measured_speed;
    wire arrive_w = (err_w < match_r) && !dir_changing;
    wire overload_w = (load_pct > `MOS_LOAD_FULL);

    // ----------------------------------------
    // speed pulse generator
    // ----------------------------------------
    logic pulse_w;
    mos_pulse_gen u_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rotor_edge(rotor_edge),
        .count_sel(pcnt_w),
        .pulse_out(pulse_w)
    );

    // ----------------------------------------
    // status source select
    // ----------------------------------------
    logic sel_w;
    always_comb begin
        unique case (src_w)
            MOS_SRC_TRIP: sel_w = trip_active;
            MOS_SRC_ARRIVE: sel_w = arrive_w;
            MOS_SRC_RUN: sel_w = motor_running;
            MOS_SRC_FREE: sel_w = motor_free_run;
            MOS_SRC_CCW: sel_w = motor_ccw;
            MOS_SRC_CW: sel_w = motor_cw;
            MOS_SRC_OVERLOAD: sel_w = overload_w;
            MOS_SRC_PULSE: sel_w = pulse_w;
        endcase
    end
    wire out_nxt = sel_w ^ pol_w;
    logic out_r;

    // one flop after the mux hides selection glitches from the pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end
    assign general_status_output = out_r;

    // ----------------------------------------
    // display value
    // ----------------------------------------
    // speed items are scaled; a zero denominator shows the raw value
    wire is_spd_w = (mon_w == MOS_MON_SPEED) || (mon_w == MOS_MON_SPD_CMD);
    wire [15:0] spd_src_w = (mon_w == MOS_MON_SPD_CMD) ? cmd_r : measured_speed;
    wire [31:0] spd_mul_w = spd_src_w * disp_num_r;
    // a full divider is costly but runs at most once per cycle
    wire [31:0] spd_div_w = (disp_den_r == 16'h0000) ? {16'h0000, spd_src_w}
                            : spd_mul_w / {16'h0000, disp_den_r};
    logic [31:0] raw_w;
    always_comb begin
        unique case (mon_w)
            MOS_MON_TORQUE: raw_w = {24'h000000, torque_pct};
            MOS_MON_AVG_LOAD: raw_w = {24'h000000, avg_load_pct};
            MOS_MON_DC_VOLT: raw_w = {16'h0000, dc_bus_volt};
            default: raw_w = spd_div_w;
        endcase
    end
    // five digits at most, larger values pin to all nines
    wire [31:0] clip_w = (raw_w > `MOS_DISP_MAX) ? `MOS_DISP_MAX : raw_w;
    logic [16:0] disp_r;
    mos_mon_type item_r;

    // item follows the setting from reset so power-up shows it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            disp_r <= 17'h00000;
            item_r <= MOS_MON_SPEED;
        end else begin
            disp_r <= clip_w[16:0];
            item_r <= mon_w;
        end
    end
    assign display_value = disp_r;
    assign display_item = item_r;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    wire [15:0] status_w = {8'h00, out_r, arrive_w, overload_w, motor_cw,
                            motor_ccw, motor_free_run, motor_running, trip_active};
    always_comb begin
        unique case (reg_addr)
            `MOS_A_CTRL: rd_mux_w = ctrl_r;
            `MOS_A_LOW_LIM: rd_mux_w = low_lim_r;
            `MOS_A_UP_LIM: rd_mux_w = up_lim_r;
            `MOS_A_TORQ: rd_mux_w = {8'h00, torq_r};
            `MOS_A_MATCH: rd_mux_w = match_r;
            `MOS_A_INT_SPD: rd_mux_w = int_clamp_w;
            `MOS_A_DISP_NUM: rd_mux_w = disp_num_r;
            `MOS_A_DISP_DEN: rd_mux_w = disp_den_r;
            `MOS_A_STATUS: rd_mux_w = status_w;
            `MOS_A_CMD_SPD: rd_mux_w = cmd_r;
            `MOS_A_DISP: rd_mux_w = disp_r[15:0];
            default: rd_mux_w = 16'h0000; // unmapped reads zero
        endcase
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= reg_rd ? rd_mux_w : 16'h0000;
        end
    end
    assign reg_rdata = rdata_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_TRIP_RESET_ONLY_TRIPPED: assert property (@(posedge core_clk) disable iff (!rst_n)
        trip_reset_accept |-> $past(trip_active) && $past(trip_reset_req))
        else $error("trip reset accepted without a trip");
    AST_TRIP_RESET_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(trip_reset_accept) |-> $past(hold_r) == 24'(TRIP_HOLD_CYC - 1))
        else $error("trip reset accepted before hold time");
    AST_ZERO_VOLT_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        (analog_sel_w && analog_code == 10'h000 && $stable(low_lim_r)) |=> speed_command == $past(low_lim_r))
        else $error("zero input must command lower limit");
    AST_FULL_VOLT_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (analog_sel_w && analog_code == `MOS_ADC_FULL && up_lim_r >= low_lim_r
         && $stable(up_lim_r)) |=> speed_command == $past(up_lim_r))
        else $error("full input must command upper limit");
    AST_INT_CLAMP: assert property (@(posedge core_clk) disable iff (!rst_n)
        !analog_sel_w |=> speed_command <= $past(up_lim_r))
        else $error("internal speed above upper limit");
    AST_OUT_FOLLOWS_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> general_status_output == $past(out_nxt))
        else $error("status output not registered from source");
    AST_TRIP_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
        (src_w == MOS_SRC_TRIP && !pol_w && trip_active) |=> general_status_output)
        else $error("trip source not driven");
    AST_RUN_POL: assert property (@(posedge core_clk) disable iff (!rst_n)
        (src_w == MOS_SRC_RUN && pol_w) |=> general_status_output == !$past(motor_running))
        else $error("inverted run output wrong");
    AST_OVERLOAD_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
        (src_w == MOS_SRC_OVERLOAD && !pol_w) |=> general_status_output == ($past(load_pct) > `MOS_LOAD_FULL))
        else $error("overload output wrong");
    AST_ARRIVE_DIR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (src_w == MOS_SRC_ARRIVE && !pol_w && dir_changing) |=> !general_status_output)
        else $error("arrival shown during direction change");
    COV_TRIP_RESET: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(trip_reset_accept));
    COV_ARRIVE: cover property (@(posedge core_clk) disable iff (!rst_n)
        src_w == MOS_SRC_ARRIVE && arrive_w ##1 general_status_output);
    COV_CLAMPED: cover property (@(posedge core_clk) disable iff (!rst_n)
        int_spd_r > up_lim_r);
endmodule : mos_top

// File: inc/mos_params.svh
// holds the named offsets, field positions, reset values and timing figures
// assumes one 50 MHz core clock and a plain register port with 8-bit address
`ifndef MOS_PARAMS_SVH
`define MOS_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MOS_A_CTRL 8'h00
`define MOS_A_LOW_LIM 8'h04
`define MOS_A_UP_LIM 8'h08
`define MOS_A_TORQ 8'h0C
`define MOS_A_MATCH 8'h10
`define MOS_A_INT_SPD 8'h14
`define MOS_A_DISP_NUM 8'h18
`define MOS_A_DISP_DEN 8'h1C
`define MOS_A_STATUS 8'h20
`define MOS_A_CMD_SPD 8'h24
`define MOS_A_DISP 8'h28
// ----------------------------------------
// control fields
// ----------------------------------------
`define MOS_F_SRC 2:0
`define MOS_F_POL 3
`define MOS_F_PCNT 6:4
`define MOS_F_MON 9:7
`define MOS_F_ANALOG 10
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define MOS_RST_CTRL 16'h0000
`define MOS_RST_LOW 16'h0000
`define MOS_RST_UP 16'h0FA0
`define MOS_RST_TORQ 8'h64
`define MOS_RST_MATCH 16'h0032
`define MOS_RST_ONE 16'h0001
`define MOS_ADC_FULL 10'h3FF
`define MOS_ADC_SHIFT 10
`define MOS_LOAD_FULL 8'h64
`define MOS_DISP_MAX 32'h0001869F
// ----------------------------------------
// timing
// ----------------------------------------
`define MOS_CLK_MHZ 50
`define MOS_TRIP_HOLD_MS 200
`define MOS_TRIP_HOLD_CYC (`MOS_TRIP_HOLD_MS * 1000 * `MOS_CLK_MHZ)
// rotor sensor edges per revolution, twice the largest pulse count
`define MOS_EDGES_PER_REV 48
`endif

// File: inc/mos_pkg.sv
// holds the enumerated types of the output select and speed limit block
// assumes mos_params.svh supplies all numeric constants
package mos_pkg;
    // ----------------------------------------
    // status output sources
    // ----------------------------------------
    typedef enum logic [2:0] {
        MOS_SRC_TRIP,
        MOS_SRC_ARRIVE,
        MOS_SRC_RUN,
        MOS_SRC_FREE,
        MOS_SRC_CCW,
        MOS_SRC_CW,
        MOS_SRC_OVERLOAD,
        MOS_SRC_PULSE
    } mos_src_type;
    // ----------------------------------------
    // power-up monitor items
    // ----------------------------------------
    typedef enum logic [2:0] {
        MOS_MON_SPEED,
        MOS_MON_TORQUE,
        MOS_MON_AVG_LOAD,
        MOS_MON_SPD_CMD,
        MOS_MON_DC_VOLT
    } mos_mon_type;
endpackage : mos_pkg

// File: src/mos_pulse_gen.sv
// holds the speed pulse generator fed by rotor sensor edges
// assumes rotor_edge is a one-cycle pulse per sensor transition
`timescale 1ns/1ps
`include "mos_params.svh"
module mos_pulse_gen (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rotor_edge,
    input wire logic [2:0] count_sel,
    output logic pulse_out
);
    import mos_pkg::*;
    logic [4:0] div_w; // edges per output toggle
    logic [4:0] cnt_r; // edges seen since last toggle
    logic [4:0] cnt_nxt;
    logic pulse_r;
    logic hit_w;
    // ----------------------------------------
    // divider lookup: 48 edges, two toggles per pulse
    // ----------------------------------------
    always_comb begin
        unique case (count_sel)
            3'h0: div_w = 5'h18; // 1 per rev
            3'h1: div_w = 5'h0C; // 2 per rev
            3'h2: div_w = 5'h08; // 3 per rev
            3'h3: div_w = 5'h06; // 4 per rev
            3'h4: div_w = 5'h04; // 6 per rev
            3'h5: div_w = 5'h03; // 8 per rev
            3'h6: div_w = 5'h02; // 12 per rev
            3'h7: div_w = 5'h01; // 24 per rev
        endcase
    end
    // a change of count_sel mid-count lengthens or shortens only one half period
    assign hit_w = rotor_edge && (cnt_r >= div_w - 5'h01);
    assign cnt_nxt = hit_w ? 5'h00 : cnt_r + 5'h01;
    // ----------------------------------------
    // edge counter and toggle
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
            pulse_r <= 1'b0;
        end else if (rotor_edge) begin
            cnt_r <= cnt_nxt;
            pulse_r <= pulse_r ^ hit_w;
        end
    end
    assign pulse_out = pulse_r;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_PULSE_NEEDS_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(pulse_r) |-> $past(rotor_edge))
        else $error("pulse toggled without rotor edge");
    AST_PULSE_FULL_RATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rotor_edge && count_sel == 3'h7) |=> $changed(pulse_r))
        else $error("24 per rev must toggle on every edge");
    COV_PULSE_TOGGLE: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(pulse_r));
endmodule : mos_pulse_gen

// File: test/mos_ctrl_model.sv
// controller model: rotor sensor edges and trip reset button
// assumes one core clock; drives only on rising edges
`timescale 1ns/1ps
module mos_ctrl_model (
    input wire logic core_clk,
    output logic rotor_edge,
    output logic trip_reset_req
);
    // both lines idle low between requests
    initial begin
        rotor_edge = 1'b0;
        trip_reset_req = 1'b0;
    end
    // one sensor transition every four cycles, a steady rotation
    task spin(input int n);
        repeat (n) begin
            @(posedge core_clk);
            rotor_edge <= 1'b1;
            @(posedge core_clk);
            rotor_edge <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask : spin
    // hold the reset combination for n cycles, then release
    task press(input int n);
        @(posedge core_clk);
        trip_reset_req <= 1'b1;
        repeat (n) @(posedge core_clk);
        trip_reset_req <= 1'b0;
    endtask : press
endmodule : mos_ctrl_model

// File: test/mos_top_tb_top.sv
// bench for the status output select and speed limit block
// assumes the controller model supplies rotor edges and trip reset
`timescale 1ns/1ps
`include "mos_params.svh"
module mos_top_tb_top;
    import mos_pkg::*;
    logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, dir_chg = 0;
    logic [7:0] reg_addr = 0, load = 8'h64;
    logic [15:0] reg_wdata = 0, meas = 0, d, rdata, spd;
    logic [9:0] adc = 0;
    logic [4:0] lv = 0; // trip, run, free, ccw, cw
    logic rot, trq, gso, acc, last = 0;
    logic [7:0] tq = 8'h37, al = 8'h2A; // monitor inputs: torque, average load
    logic [15:0] dcv = 16'h0136; // monitor input: dc bus
    wire l0 = lv[0], l1 = lv[1], l2 = lv[2], l3 = lv[3], l4 = lv[4];
    logic [16:0] disp;
    logic [7:0] tlim;
    mos_mon_type item;
    int err_count = 0, checks = 0, cyc = 0, accs = 0, tog = 0;
    logic [7:0] ra[7] = '{`MOS_A_CTRL, `MOS_A_UP_LIM, `MOS_A_TORQ, `MOS_A_MATCH,
        `MOS_A_DISP_NUM, `MOS_A_DISP_DEN, 8'hFE};
    logic [15:0] rv[7] = '{`MOS_RST_CTRL, `MOS_RST_UP, 16'h0064, `MOS_RST_MATCH,
        `MOS_RST_ONE, `MOS_RST_ONE, 16'h0000};
    logic [2:0] st[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [16:0] dv[5] = '{17'h005DC, 17'h00037, 17'h0002A, 17'h005DC, 17'h00136};
    int pn[8] = '{1, 2, 3, 4, 6, 8, 12, 24};
    // short trip hold keeps the run brief
    mos_top #(.TRIP_HOLD_CYC(8)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .trip_active(l0), .trip_reset_req(trq), .analog_code(adc), .measured_speed(meas),
        .motor_running(l1), .motor_free_run(l2), .motor_ccw(l3), .motor_cw(l4),
        .dir_changing(dir_chg), .load_pct(load), .torque_pct(tq), .avg_load_pct(al),
        .dc_bus_volt(dcv), .rotor_edge(rot), .general_status_output(gso),
        .trip_reset_accept(acc), .speed_command(spd), .torque_limit_pct(tlim),
        .display_value(disp), .display_item(item));
    mos_ctrl_model i_ctl (.core_clk(core_clk), .rotor_edge(rot), .trip_reset_req(trq));
    initial forever #10 core_clk = ~core_clk;
    // accept pulses, output toggles and the hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (acc === 1'b1) accs++;
        if (gso !== last) tog++;
        last = gso;
        if (cyc > 20000) begin
            err_count++;
            conclude();
        end
    end
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // wait whole cycles, then let the edge updates land
    task w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : w
    task chk(input string n, input logic [16:0] e, input logic [16:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task conclude();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        w(1);
        chk("tlim", 17'h64, 17'(tlim));
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk("reg", 17'(rv[i]), 17'(d));
        end
        // each level source but arrival, then inverted; load 100 is not overload
        for (int i = 0; i < 6; i++) begin
            wr(`MOS_A_CTRL, {13'h0, st[i]});
            w(3);
            chk("out", 17'h0, 17'(gso));
            @(posedge core_clk);
            if (i < 5) lv[i] <= 1'b1;
            else load <= 8'h65;
            w(3);
            chk("out", 17'h1, 17'(gso));
            wr(`MOS_A_CTRL, {12'h0, 1'b1, st[i]});
            w(3);
            chk("out", 17'h0, 17'(gso));
            @(posedge core_clk) lv <= 5'h0;
            load <= 8'h64;
        end
        wr(`MOS_A_LOW_LIM, 16'd100);
        wr(`MOS_A_UP_LIM, 16'd1100);
        wr(`MOS_A_INT_SPD, 16'h2000);
        rd(`MOS_A_INT_SPD);
        chk("int", 17'd1100, 17'(d));
        wr(`MOS_A_CTRL, 16'h0400);
        w(3);
        chk("cmd", 17'd100, 17'(spd));
        @(posedge core_clk) adc <= 10'h3FF;
        w(3);
        chk("cmd", 17'd1100, 17'(spd));
        // arrival window of 50 around 1000, upper edge of the window
        wr(`MOS_A_INT_SPD, 16'd1000);
        wr(`MOS_A_CTRL, 16'h0001);
        @(posedge core_clk) meas <= 16'd1049;
        w(3);
        chk("arr", 17'h1, 17'(gso));
        @(posedge core_clk) meas <= 16'd1050;
        w(3);
        chk("arr", 17'h0, 17'(gso));
        @(posedge core_clk) meas <= 16'd1000;
        dir_chg <= 1'b1;
        w(3);
        chk("arr", 17'h0, 17'(gso));
        @(posedge core_clk) dir_chg <= 1'b0;
        w(3);
        chk("arr", 17'h1, 17'(gso));
        wr(`MOS_A_DISP_NUM, 16'd3);
        wr(`MOS_A_DISP_DEN, 16'd2);
        for (int i = 0; i < 5; i++) begin
            wr(`MOS_A_CTRL, 16'(i << 7));
            w(3);
            chk("item", 17'(i), 17'(item));
            chk("disp", dv[i], disp);
        end
        // reset ignored untripped, short press refused, long press once
        i_ctl.press(20);
        w(2);
        chk("acc", 17'h0, 17'(accs));
        @(posedge core_clk) lv[0] <= 1'b1;
        i_ctl.press(4);
        w(2);
        chk("acc", 17'h0, 17'(accs));
        i_ctl.press(20);
        w(2);
        chk("acc", 17'h1, 17'(accs));
        @(posedge core_clk) lv[0] <= 1'b0;
        // one warm-up turn, then count toggles over one full turn
        for (int p = 0; p < 8; p++) begin
            wr(`MOS_A_CTRL, 16'h0007 | 16'(p << 4));
            i_ctl.spin(48);
            // clear after the edge so the last warm-up toggle is not counted
            #1 tog = 0;
            i_ctl.spin(48);
            w(3);
            chk("tog", 17'(2 * pn[p]), 17'(tog));
        end
        conclude();
    end
endmodule : mos_top_tb_top
